/* File: hw/sif_defs.svh */
// register map, field positions, reset values and codes of the sensor register bank
// assumes one clock domain; addresses are the byte offsets of the serial register port
`ifndef SIF_DEFS_SVH
`define SIF_DEFS_SVH
`define SIF_A_ICFG 8'h14
`define SIF_A_ISRC 8'h15
`define SIF_A_QCFG 8'h16
`define SIF_A_QCNT 8'h17
`define SIF_A_QSEL 8'h18
`define SIF_A_RSV0 8'h1C
`define SIF_A_TLO 8'h1D
`define SIF_A_TMI 8'h1E
`define SIF_A_THI 8'h1F
`define SIF_A_PLO 8'h20
`define SIF_A_PMI 8'h21
`define SIF_A_PHI 8'h22
`define SIF_A_RSV1 8'h23
`define SIF_A_RSV4 8'h26
`define SIF_A_IFLG 8'h27
`define SIF_A_STAT 8'h28
`define SIF_A_QDAT 8'h29
`define SIF_A_NROW 8'h2B
`define SIF_A_NLO 8'h2C
`define SIF_A_NHI 8'h2D
`define SIF_A_PATH 8'h30
`define SIF_A_COEF 8'h31
`define SIF_ICFG_RST 8'h35
`define SIF_PATH_RST 8'h03
`define SIF_RES_RST 8'h7F
`define SIF_QDAT_RST 8'h7F
`define SIF_ISRC_MASK 8'h0F
`define SIF_QCFG_MASK 8'h3F
`define SIF_QSEL_MASK 8'h1F
`define SIF_NROW_MASK 8'h7F
`define SIF_PATH_MASK 8'hFC
`define SIF_COEF_MASK 8'h3F
`define SIF_B_MODE 0
`define SIF_B_POL 1
`define SIF_B_OD 2
`define SIF_B_EN 3
`define SIF_B_QMODE 5
`define SIF_F_POR 4
`define SIF_B_RDY 1
`define SIF_B_ERR 2
`define SIF_B_FLUSH 2
`define SIF_B_SH_T 3
`define SIF_B_FI_T 4
`define SIF_B_SH_P 5
`define SIF_B_FI_P 6
`define SIF_B_OOR 7
`define SIF_FS_OFF 2'h0
`define SIF_FS_P 2'h2
`define SIF_FS_PT 2'h3
`endif

/* File: hw/sif_pkg.sv */
// types shared by the sensor register bank and its queue
// assumes the defs header is included by the files that need numbers
package sif_pkg;
  // one conversion result, before and after the low-pass filter
  typedef struct packed {
    logic [23:0] raw_t;
    logic [23:0] filt_t;
    logic [23:0] raw_p;
    logic [23:0] filt_p;
  } sif_sample_t;
  // one stored queue frame
  typedef struct packed {
    logic [23:0] press;
    logic [23:0] temp;
  } sif_frame_t;
  // settings handed to the measurement and filter logic
  typedef struct packed {
    logic [2:0] iir_t;
    logic [2:0] iir_p;
    logic flush;
    logic oor_post;
    logic [3:0] pad_drv;
    logic [5:0] row;
    logic prog_en;
    logic [15:0] word;
  } sif_cfg_t;
endpackage : sif_pkg

/* File: hw/sif_fifo.sv */
// synchronous frame queue with valid/ready on both sides
// assumes one clock; a push into a full queue is taken only with a pop in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sif_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths that the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sif_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  // full still accepts when a pop frees a slot in the same cycle
  assign o_out_valid = (cnt_reg != '0);
  assign o_in_ready = (cnt_reg != (AW + 1)'(DEPTH)) || i_out_ready;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rp_reg];
  assign o_count = cnt_reg;
  // storage has no reset, only the pointers and the fill level do
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wp_reg] <= i_in_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sif_fifo
`default_nettype wire

/* File: hw/sif_regs.sv */
// sensor register bank: interrupt pin, queue, results, nonvolatile and filter settings
// assumes a one-cycle register port from the serial front end and a conversion engine
`timescale 1ns/10ps
`default_nettype none
`include "sif_defs.svh"
module sif_regs import sif_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_conv_busy,
  input wire logic i_sample_valid,
  input wire sif_sample_t i_sample,
  input wire logic i_oor_event,
  input wire logic i_nvm_rdy,
  input wire logic i_nvm_cmd,
  input wire logic i_nvm_err,
  input wire logic i_int_in,
  output logic o_int_out,
  output logic o_int_oe_n,
  output sif_cfg_t o_cfg
);
  // the frame count register has six bits
  if (DEPTH > 32 || DEPTH < 2) begin : g_bad_depth
    $error("sif_regs depth must fit the 6-bit count");
  end
  logic [7:0] icfg_reg, isrc_reg, qcfg_reg, qsel_reg;
  logic [7:0] nrow_reg, nlo_reg, nhi_reg, path_reg, coef_reg;
  logic [23:0] temp_reg, press_reg;
  logic [4:0] flags_reg;
  logic rdy_reg, err_reg, boot_reg, full_d_reg, thr_d_reg;
  logic int_act_reg, int_out_reg, int_oe_n_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic [2:0] byte_idx_reg;
  logic [2:0] dec_cnt_reg;
  logic [$clog2(DEPTH):0] qcount;
  logic wr, rd, lock, q_in_ready, q_valid, q_pop, push_want, drop;
  logic ev_full, ev_thr, fire, int_act_next, int_level;
  logic [4:0] ev;
  logic [2:0] last_idx, base_idx;
  sif_frame_t q_frame, q_head;
  logic [47:0] head_bits;

  assign wr = i_reg_wr;
  assign rd = i_reg_rd;
  assign lock = i_conv_busy;

  // host-written settings; these fields take writes even during a conversion
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      icfg_reg <= `SIF_ICFG_RST;
      isrc_reg <= '0;
      qcfg_reg <= '0;
      qsel_reg <= '0;
    end else if (wr) begin
      if (i_reg_addr == `SIF_A_ICFG) icfg_reg <= i_reg_wdata;
      if (i_reg_addr == `SIF_A_ISRC) isrc_reg <= i_reg_wdata & `SIF_ISRC_MASK;
      if (i_reg_addr == `SIF_A_QCFG) qcfg_reg <= i_reg_wdata & `SIF_QCFG_MASK;
      if (i_reg_addr == `SIF_A_QSEL) qsel_reg <= i_reg_wdata & `SIF_QSEL_MASK;
    end
  end

  // conversion-locked registers: a write in a busy cycle is dropped without trace
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nrow_reg <= '0;
      nlo_reg <= '0;
      nhi_reg <= '0;
      path_reg <= `SIF_PATH_RST;
      coef_reg <= '0;
    end else if (wr && !lock) begin
      if (i_reg_addr == `SIF_A_NROW) nrow_reg <= i_reg_wdata & `SIF_NROW_MASK;
      if (i_reg_addr == `SIF_A_NLO) nlo_reg <= i_reg_wdata;
      if (i_reg_addr == `SIF_A_NHI) nhi_reg <= i_reg_wdata;
      if (i_reg_addr == `SIF_A_PATH) begin
        // reserved low bits keep their reset ones
        path_reg <= (i_reg_wdata & `SIF_PATH_MASK) | `SIF_PATH_RST;
      end
      if (i_reg_addr == `SIF_A_COEF) coef_reg <= i_reg_wdata & `SIF_COEF_MASK;
    end
  end

  // result registers follow the pre or post filter value picked per quantity
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      temp_reg <= {3{`SIF_RES_RST}};
      press_reg <= {3{`SIF_RES_RST}};
    end else if (i_sample_valid) begin
      temp_reg <= path_reg[`SIF_B_SH_T] ? i_sample.filt_t : i_sample.raw_t;
      press_reg <= path_reg[`SIF_B_SH_P] ? i_sample.filt_p : i_sample.raw_p;
    end
  end

  // queue frame and decimation: store one sample, then skip the programmed number
  assign q_frame.temp = path_reg[`SIF_B_FI_T] ? i_sample.filt_t : i_sample.raw_t;
  assign q_frame.press = path_reg[`SIF_B_FI_P] ? i_sample.filt_p : i_sample.raw_p;
  assign push_want = i_sample_valid && (qsel_reg[1:0] != `SIF_FS_OFF)
    && (dec_cnt_reg == '0);
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      dec_cnt_reg <= '0;
    end else if (i_sample_valid) begin
      dec_cnt_reg <= (dec_cnt_reg >= qsel_reg[4:2]) ? 3'h0 : dec_cnt_reg + 3'h1;
    end
  end

  // stream mode discards the oldest frame to make room; stop mode refuses the new one
  assign drop = push_want && !qcfg_reg[`SIF_B_QMODE]
    && (qcount == ($clog2(DEPTH) + 1)'(DEPTH));
  assign q_pop = q_valid && rd && (i_reg_addr == `SIF_A_QDAT) && (byte_idx_reg == last_idx);

  sif_fifo #(
    .WIDTH(48),
    .DEPTH(DEPTH)
  ) u_queue (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(push_want),
    .o_in_ready(q_in_ready),
    .i_in_data(q_frame),
    .o_out_valid(q_valid),
    .i_out_ready(q_pop || drop),
    .o_out_data(q_head),
    .o_count(qcount)
  );

  // byte walk over the head frame: temperature bytes first, then pressure
  assign base_idx = (qsel_reg[1:0] == `SIF_FS_P) ? 3'h3 : 3'h0;
  assign last_idx = (qsel_reg[1:0] == `SIF_FS_PT) ? 3'h5 : 3'h2;
  assign head_bits = {q_head.press, q_head.temp};
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || drop) begin
      byte_idx_reg <= '0; // a dropped head restarts the walk
    end else if (q_valid && rd && (i_reg_addr == `SIF_A_QDAT)) begin
      byte_idx_reg <= (byte_idx_reg == last_idx) ? 3'h0 : byte_idx_reg + 3'h1;
    end
  end

  // level edges of full and watermark become one-cycle events
  assign ev_full = (qcount == ($clog2(DEPTH) + 1)'(DEPTH)) && !full_d_reg;
  assign ev_thr = (qcfg_reg[4:0] != 5'h00)
    && (qcount >= ($clog2(DEPTH) + 1)'(qcfg_reg[4:0])) && !thr_d_reg;
  assign ev = {boot_reg, i_oor_event, ev_thr, ev_full, i_sample_valid};
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      full_d_reg <= 1'b0;
      thr_d_reg <= 1'b0;
      boot_reg <= 1'b1; // reset-done event fires in the first cycle after release
    end else begin
      full_d_reg <= (qcount == ($clog2(DEPTH) + 1)'(DEPTH));
      thr_d_reg <= (qcfg_reg[4:0] != 5'h00)
        && (qcount >= ($clog2(DEPTH) + 1)'(qcfg_reg[4:0]));
      boot_reg <= 1'b0;
    end
  end

  // sticky status flags; a new event in the reading cycle survives the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flags_reg <= '0;
    end else if (rd && i_reg_addr == `SIF_A_IFLG) begin
      flags_reg <= ev;
    end else begin
      flags_reg <= flags_reg | ev;
    end
  end

  // nonvolatile status: ready follows the engine, error is taken per new command
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdy_reg <= 1'b1;
      err_reg <= 1'b0;
    end else begin
      rdy_reg <= i_nvm_rdy;
      if (i_nvm_cmd) err_reg <= i_nvm_err;
    end
  end

  // interrupt: enabled causes and reset-done fire it; latched holds, pulsed is one cycle
  assign fire = (|(ev[3:0] & isrc_reg[3:0])) || ev[`SIF_F_POR];
  always_comb begin
    if (fire) begin
      int_act_next = 1'b1;
    end else if (icfg_reg[`SIF_B_MODE] && !(rd && i_reg_addr == `SIF_A_IFLG)) begin
      int_act_next = int_act_reg;
    end else begin
      int_act_next = 1'b0;
    end
  end
  assign int_level = (int_act_next && icfg_reg[`SIF_B_EN])
    ? icfg_reg[`SIF_B_POL] : !icfg_reg[`SIF_B_POL];
  // open drain only pulls low; the high level is left to the board pull-up
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      int_act_reg <= 1'b0;
      // reset config is open drain and disabled, so the pin starts released
      int_out_reg <= 1'b0;
      int_oe_n_reg <= 1'b1;
    end else begin
      int_act_reg <= int_act_next;
      int_out_reg <= icfg_reg[`SIF_B_OD] ? 1'b0 : int_level;
      int_oe_n_reg <= icfg_reg[`SIF_B_OD] ? int_level : 1'b0;
    end
  end

  // read mux; reserved registers, bits and unmapped addresses read zero, except the two reserved low path bits, which read one
  always_comb begin
    rdata_next = 8'h00;
    unique case (i_reg_addr)
      `SIF_A_ICFG: rdata_next = icfg_reg;
      `SIF_A_ISRC: rdata_next = isrc_reg;
      `SIF_A_QCFG: rdata_next = qcfg_reg;
      `SIF_A_QCNT: rdata_next = {2'h0, 6'(qcount)};
      `SIF_A_QSEL: rdata_next = qsel_reg;
      `SIF_A_TLO: rdata_next = temp_reg[7:0];
      `SIF_A_TMI: rdata_next = temp_reg[15:8];
      `SIF_A_THI: rdata_next = temp_reg[23:16];
      `SIF_A_PLO: rdata_next = press_reg[7:0];
      `SIF_A_PMI: rdata_next = press_reg[15:8];
      `SIF_A_PHI: rdata_next = press_reg[23:16];
      `SIF_A_IFLG: rdata_next = {3'h0, flags_reg};
      `SIF_A_STAT: begin
        rdata_next[`SIF_B_RDY] = rdy_reg;
        rdata_next[`SIF_B_ERR] = err_reg;
      end
      `SIF_A_QDAT: begin
        rdata_next = q_valid
          ? head_bits[8 * (32'(byte_idx_reg) + 32'(base_idx)) +: 8]
          : `SIF_QDAT_RST;
      end
      `SIF_A_NROW: rdata_next = nrow_reg;
      `SIF_A_NLO: rdata_next = nlo_reg;
      `SIF_A_NHI: rdata_next = nhi_reg;
      `SIF_A_PATH: rdata_next = path_reg;
      `SIF_A_COEF: rdata_next = coef_reg;
      default: rdata_next = 8'h00;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_reg <= `SIF_QDAT_RST;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_int_out = int_out_reg;
  assign o_int_oe_n = int_oe_n_reg;
  // settings for the filter and nonvolatile engines, straight from the registers
  assign o_cfg.iir_t = coef_reg[2:0];
  assign o_cfg.iir_p = coef_reg[5:3];
  assign o_cfg.flush = path_reg[`SIF_B_FLUSH];
  assign o_cfg.oor_post = path_reg[`SIF_B_OOR];
  assign o_cfg.pad_drv = icfg_reg[7:4];
  assign o_cfg.row = nrow_reg[5:0];
  assign o_cfg.prog_en = nrow_reg[6];
  assign o_cfg.word = {nhi_reg, nlo_reg};

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_flag_read;
    rd && i_reg_addr == `SIF_A_IFLG && ev == '0;
  endsequence
  sequence s_pulse_fire;
    !icfg_reg[`SIF_B_MODE] && fire ##1 !fire && !icfg_reg[`SIF_B_MODE];
  endsequence
  property p_flag_clear;
    s_flag_read |=> flags_reg == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");
  property p_rsv_zero;
    rd && i_reg_addr >= `SIF_A_RSV1 && i_reg_addr <= `SIF_A_RSV4 |=> o_reg_rdata == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
  property p_lock;
    wr && lock && i_reg_addr == `SIF_A_NROW |=> $stable(nrow_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  property p_latch_hold;
    icfg_reg[`SIF_B_MODE] && int_act_reg && !rd ##1 (!rd && icfg_reg[`SIF_B_MODE]) [*3]
      |-> int_act_reg;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched interrupt lost");
  property p_pulse_one;
    s_pulse_fire |=> !int_act_reg;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");
  property p_pol;
    int_act_reg && icfg_reg[`SIF_B_EN] && !icfg_reg[`SIF_B_OD] && $stable(icfg_reg)
      |-> o_int_out == icfg_reg[`SIF_B_POL];
  endproperty
  a_pol: assert property (p_pol) else $error("interrupt polarity wrong");
  property p_od;
    icfg_reg[`SIF_B_OD] && $stable(icfg_reg) |-> !o_int_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_disabled;
    !icfg_reg[`SIF_B_EN] && !icfg_reg[`SIF_B_OD] && $stable(icfg_reg)
      |-> o_int_out == !icfg_reg[`SIF_B_POL];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled interrupt asserted");
  property p_thr_off;
    qcfg_reg[4:0] == 5'h00 && !flags_reg[2] |=> !flags_reg[2];
  endproperty
  a_thr_off: assert property (p_thr_off) else $error("watermark fired while off");
endmodule : sif_regs
`default_nettype wire

/* File: test/sif_host_model.sv */
// conversion engine model that feeds results into the register bank
// assumes one clock; the bench raises i_start to hold a conversion open
`timescale 1ns/10ps
`default_nettype none
module sif_host_model import sif_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire sif_sample_t i_value,
  output logic o_busy,
  output logic o_valid,
  output sif_sample_t o_sample
);
  // busy follows the request; the result shows for one cycle as busy drops
  // between results the bus toggles so a stale value can never pass for new data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      o_valid <= 1'b0;
      o_sample <= '0;
    end else begin
      o_busy <= i_start;
      o_valid <= o_busy & ~i_start;
      o_sample <= (o_busy & ~i_start) ? i_value : ~o_sample;
    end
  end
endmodule : sif_host_model
`default_nettype wire

/* File: test/sif_regs_tb.sv */
// self-checking bench for the sensor register bank
// assumes sif_pkg, the defs header and the conversion model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "sif_defs.svh"
module sif_regs_tb import sif_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, oor = 1'b0;
  logic nrdy = 1'b1, ncmd = 1'b0, nerr = 1'b0, start = 1'b0, pol_now = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, e;
  logic int_out, oe_n, busy, sv;
  wire logic pin;
  sif_sample_t val = '0, smp, s;
  sif_sample_t hist [0:17];
  sif_cfg_t cfg;
  logic [7:0] wv [0:8];
  int err_count = 0, tests_run = 0, seed = 78200, hi = 0, i, k, f;
  localparam logic [15:0] RST_TAB [24] = '{16'h1435, 16'h1500, 16'h1600, 16'h1700,
    16'h1800, 16'h1C00, 16'h1D7F, 16'h1E7F, 16'h1F7F, 16'h207F, 16'h217F, 16'h227F,
    16'h2300, 16'h2400, 16'h2500, 16'h2600, 16'h2802, 16'h297F, 16'h2B00, 16'h2C00,
    16'h2D00, 16'h3003, 16'h3100, 16'h4000};
  localparam logic [15:0] RW_TAB [9] = '{16'h14FF, 16'h150F, 16'h163F, 16'h181F,
    16'h2B7F, 16'h2CFF, 16'h2DFF, 16'h30FC, 16'h313F};
  localparam logic [15:0] IRQ_TAB [6] = '{16'h0A01, 16'h0A00, 16'h0201, 16'h0B01,
    16'h0D01, 16'h0901};

  // interrupt wire with a pull-up, so a released open-drain pin reads high
  assign pin = oe_n ? 1'b1 : int_out;

  initial begin
    forever #2.5 clk = ~clk;
  end

  sif_host_model host (.i_sys_clk(clk), .i_reset(rst), .i_start(start), .i_value(val),
    .o_busy(busy), .o_valid(sv), .o_sample(smp));
  sif_regs #(.DEPTH(16)) uut (.i_sys_clk(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wr(reg_wr), .i_reg_wdata(wdata), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_conv_busy(busy), .i_sample_valid(sv), .i_sample(smp), .i_oor_event(oor),
    .i_nvm_rdy(nrdy), .i_nvm_cmd(ncmd), .i_nvm_err(nerr), .i_int_in(pin),
    .o_int_out(int_out), .o_int_oe_n(oe_n), .o_cfg(cfg));

  // count cycles the pin sits at its active level
  always @(posedge clk) begin
    if (pin === pol_now) hi = hi + 1;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : chk_rd

  task automatic pulse_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : pulse_rd

  // one conversion: busy for two cycles, then the result
  task automatic conv(input sif_sample_t v);
    @(posedge clk);
    val <= v;
    start <= 1'b1;
    repeat (2) @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : conv

  function automatic logic [7:0] res_byte(sif_sample_t v, logic tp, logic pp, int n);
    logic [23:0] t;
    logic [23:0] p;
    t = tp ? v.filt_t : v.raw_t;
    p = pp ? v.filt_p : v.raw_p;
    return (n < 3) ? t[8*n +: 8] : p[8*(n-3) +: 8];
  endfunction : res_byte

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #400000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // reset config is disabled open drain, so the pull-up holds the pin high
    #1 chk("pin", 8'h01, {7'h0, pin});
    for (i = 0; i < 24; i++) chk_rd(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    chk_rd(8'h27, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk("pin", 8'h01, {7'h0, pin});
    chk_rd(8'h27, 8'h00);
    // writable fields keep only their defined bits
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 9; i++) begin
        d = 8'($random(seed));
        if (i == 0) d[7] = d[7] & d[2];
        wv[i] = d;
        wr_reg(RW_TAB[i][15:8], d);
        repeat (200) @(posedge clk);
        e = (d & RW_TAB[i][7:0]) | ((i == 7) ? 8'h03 : 8'h00);
        chk_rd(RW_TAB[i][15:8], e);
      end
    end
    chk("cfg iir", {2'h0, wv[8][5:0]}, {2'h0, cfg.iir_p, cfg.iir_t});
    chk("cfg row", {1'b0, wv[4][6:0]}, {1'b0, cfg.prog_en, cfg.row});
    chk("cfg word", wv[6], cfg.word[15:8]);
    chk("cfg flush", {7'h0, wv[7][2]}, {7'h0, cfg.flush});
    chk("cfg oor", {7'h0, wv[7][7]}, {7'h0, cfg.oor_post});
    chk("cfg drive", {4'h0, wv[0][7:4]}, {4'h0, cfg.pad_drv});
    // read-only places ignore writes
    wr_reg(8'h1D, 8'h00);
    wr_reg(8'h1C, 8'hA5);
    wr_reg(8'h17, 8'h3F);
    chk_rd(8'h1D, 8'h7F);
    chk_rd(8'h1C, 8'h00);
    chk_rd(8'h17, 8'h00);
    wr_reg(8'h18, 8'h00);
    wr_reg(8'h16, 8'h00);
    // locked fields keep their value while a conversion runs
    @(posedge clk);
    start <= 1'b1;
    for (i = 4; i < 9; i++) wr_reg(RW_TAB[i][15:8], ~wv[i]);
    start <= 1'b0;
    repeat (200) @(posedge clk);
    for (i = 4; i < 9; i++) begin
      e = (wv[i] & RW_TAB[i][7:0]) | ((i == 7) ? 8'h03 : 8'h00);
      chk_rd(RW_TAB[i][15:8], e);
    end
    // result bytes follow the pre or post filter choice
    for (k = 0; k < 2; k++) begin
      wr_reg(8'h30, k ? 8'h20 : 8'h08);
      s = {$random(seed), $random(seed), $random(seed)};
      conv(s);
      for (i = 0; i < 6; i++) chk_rd(8'(8'h1D + i), res_byte(s, !k, k, i));
    end
    chk_rd(8'h17, 8'h00);
    // interrupt modes, polarity, driver and source gating
    for (k = 0; k < 6; k++) begin
      wr_reg(8'h14, IRQ_TAB[k][15:8]);
      wr_reg(8'h15, IRQ_TAB[k][7:0]);
      pol_now = IRQ_TAB[k][9];
      pulse_rd(8'h27);
      repeat (2) @(posedge clk);
      #1 hi = 0;
      conv(val);
      repeat (10) @(posedge clk);
      #1;
      e = {7'h0, IRQ_TAB[k][11] & IRQ_TAB[k][0]};
      if (IRQ_TAB[k][8]) chk("latched", e, {7'h0, pin === pol_now});
      else chk("pulses", e, hi[7:0]);
      chk_rd(8'h27, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk("released", 8'h00, {7'h0, pin === pol_now});
    end
    @(posedge clk);
    oor <= 1'b1;
    @(posedge clk);
    oor <= 1'b0;
    chk_rd(8'h27, 8'h08);
    // nonvolatile status follows ready and the error seen at each command
    @(posedge clk);
    nrdy <= 1'b0;
    nerr <= 1'b1;
    ncmd <= 1'b1;
    @(posedge clk);
    ncmd <= 1'b0;
    chk_rd(8'h28, 8'h04);
    @(posedge clk);
    nrdy <= 1'b1;
    nerr <= 1'b0;
    ncmd <= 1'b1;
    @(posedge clk);
    ncmd <= 1'b0;
    chk_rd(8'h28, 8'h02);
    // fill in stop-on-full mode past its depth, then drain
    wr_reg(8'h30, 8'h10);
    wr_reg(8'h16, 8'h22);
    wr_reg(8'h18, 8'h03);
    for (f = 0; f < 18; f++) begin
      hist[f] = {$random(seed), $random(seed), $random(seed)};
      conv(hist[f]);
    end
    chk_rd(8'h17, 8'h10);
    chk_rd(8'h27, 8'h07);
    for (f = 0; f < 16; f++) begin
      for (i = 0; i < 6; i++) chk_rd(8'h29, res_byte(hist[f], 1'b1, 1'b0, i));
    end
    chk_rd(8'h17, 8'h00);
    chk_rd(8'h29, 8'h7F);
    // stream mode drops the oldest frame; a zero watermark stays silent
    wr_reg(8'h16, 8'h00);
    for (f = 0; f < 17; f++) conv(hist[f]);
    chk_rd(8'h17, 8'h10);
    chk_rd(8'h27, 8'h03);
    chk_rd(8'h29, res_byte(hist[1], 1'b1, 1'b0, 0));
    // second reset, then temperature frames with one sample skipped each time
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr_reg(8'h18, 8'h05);
    for (f = 0; f < 4; f++) conv(hist[f]);
    chk_rd(8'h17, 8'h02);
    for (i = 0; i < 3; i++) chk_rd(8'h29, res_byte(hist[0], 1'b0, 1'b0, i));
    chk_rd(8'h29, res_byte(hist[2], 1'b0, 1'b0, 0));
    for (i = 1; i < 3; i++) chk_rd(8'h29, res_byte(hist[2], 1'b0, 1'b0, i));
    // pressure-only frames walk the three pressure bytes and then pop
    wr_reg(8'h18, 8'h02);
    conv(hist[5]);
    for (i = 3; i < 6; i++) chk_rd(8'h29, res_byte(hist[5], 1'b0, 1'b0, i));
    chk_rd(8'h17, 8'h00);
    test_done();
  end
endmodule : sif_regs_tb
`default_nettype wire
